// *** timer_zero_pkg.sv ***
`default_nettype none
package timer_zero_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_OPTION = 8'h04;
    localparam logic [7:0] OFS_INTCTL = 8'h08;
    localparam logic [7:0] OFS_SLEEP = 8'h0c;
    // option register fields
    localparam int OPT_PS_LSB = 0;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_EDGE_BIT = 4;
    localparam int OPT_SRC_BIT = 5;
    // interrupt control fields
    localparam int ICTL_FLAG_BIT = 2;
    localparam int ICTL_EN_BIT = 5;
    // reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    // cycles of increment hold-off after a counter write
    localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    // internal phase sequence for sampling the external pin
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_t;
endpackage : timer_zero_pkg
`default_nettype wire

// *** pin_edge_sync.sv ***
`default_nettype none
module pin_edge_sync
    import timer_zero_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pinIn,
    input wire logic fallingSel,
    output logic edgePulse
);
    phase_t phase_r;
    logic sampleTwo_r;
    logic sampleFour_r;
    logic prevLevel_r;
    wire logic polLevel = sampleFour_r ^ fallingSel;
    wire logic phaseFour = (phase_r == PH_FOUR);

    // pin sampled on phase two, re-sampled on phase four [R16]
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= PH_ONE;
            sampleTwo_r <= 1'b0;
            sampleFour_r <= 1'b0;
            prevLevel_r <= 1'b0;
        end else begin
            case (phase_r)
                PH_ONE: phase_r <= PH_TWO;
                PH_TWO: phase_r <= PH_THREE;
                PH_THREE: phase_r <= PH_FOUR;
                PH_FOUR: phase_r <= PH_ONE;
                default: phase_r <= PH_ONE;
            endcase
            if (phase_r == PH_TWO) begin
                sampleTwo_r <= pinIn;
            end
            if (phaseFour) begin
                sampleFour_r <= sampleTwo_r;
                prevLevel_r <= polLevel;
            end
        end
    end

    // active edge chosen by polarity [R4]
    assign edgePulse = phaseFour & polLevel & ~prevLevel_r;
endmodule : pin_edge_sync
`default_nettype wire

// *** prescale_div.sv ***
`default_nettype none
module prescale_div
    import timer_zero_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tickIn,
    input wire logic bypass,
    input wire logic [2:0] ratioSel,
    output logic tickOut
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    wire logic [7:0] lastVal = (8'h02 << ratioSel) - 8'h01;

    always_comb begin
        count_nxt = count_r;
        if (clear || bypass) begin
            count_nxt = PRESCALE_RESET;
        end else if (tickIn) begin
            count_nxt = (count_r >= lastVal) ? PRESCALE_RESET
                                             : count_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= PRESCALE_RESET; // [R18]
        end else begin
            count_r <= count_nxt; // [R10]
        end
    end

    // ratio 2^(k+1), undivided when handed to the watchdog [R7] [R8] [R9]
    assign tickOut = bypass ? tickIn
                   : (tickIn && !clear && count_r >= lastVal);
endmodule : prescale_div
`default_nettype wire

// *** timer_zero.sv ***
// Notes on behaviour
// R1: eight-bit count register, timer of cycles or counter of pin edges.
// R2: timer mode with no prescaler adds one each cycle.
// R3: a write to the count stops counting for two cycles.
// R4: counter mode counts pin edges; edge select picks rising or falling.
// R5: source select one means pin counting, zero means cycle timing.
// R6: prescaler serves timer or watchdog; assign bit zero gives it to timer.
// R7: timer prescaler offers eight ratios from 1:2 to 1:256.
// R8: prescale field k divides by two to the power k plus one.
// R9: assign bit set: prescaler to watchdog, timer counts at 1:1.
// R10: prescaler hidden; counter writes clear it while timer owns it.
// R11: software clears watchdog and counter before moving the prescaler.
// R12: wrap from ff to 00 sets the overflow flag regardless of enable.
// R13: only software clears the overflow flag.
// R14: interrupt request only when flag and enable are both set.
// R15: sleep stops the timer so overflow cannot wake the core.
// R16: counter mode pin sampled on phase two and phase four.
// R17: count register holds its value through sleep.
// R18: reset clears counter, prescaler, flag and enable.
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`default_nettype none
module timer_zero
    import timer_zero_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic externalCountInput,
    output logic overflowIrq,
    output logic prescaleToWatchdog,
    output logic [2:0] watchdogPrescaleSelect
);
    logic [7:0] timerCount_r;
    logic [7:0] option_r;
    logic overflowFlag_r;
    logic overflowEnable_r;
    logic sleep_r;
    logic [1:0] hold_r;
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic [31:0] hrdata_r;
    logic overflowIrq_r;
    logic prescaleToWatchdog_r;
    logic [2:0] watchdogPrescale_r;
    logic [7:0] timerCount_nxt;
    logic overflowFlag_nxt;
    logic [1:0] hold_nxt;

    function automatic logic addrIs(input logic [7:0] a,
                                    input logic [7:0] ofs);
        addrIs = (a == ofs);
    endfunction : addrIs

    // bus decode
    wire logic addrPhase = hsel && hready && htrans[1];
    wire logic [7:0] aLow = haddr[7:0];
    wire logic rdCount = addrIs(aLow, OFS_COUNT);
    wire logic rdOption = addrIs(aLow, OFS_OPTION);
    wire logic rdIntctl = addrIs(aLow, OFS_INTCTL);
    wire logic rdSleep = addrIs(aLow, OFS_SLEEP);
    wire logic wrCount = wrPend_r && addrIs(wrAddr_r, OFS_COUNT);
    wire logic wrOption = wrPend_r && addrIs(wrAddr_r, OFS_OPTION);
    wire logic wrIntctl = wrPend_r && addrIs(wrAddr_r, OFS_INTCTL);
    wire logic wrSleep = wrPend_r && addrIs(wrAddr_r, OFS_SLEEP);

    // mode decode
    wire logic pinMode = option_r[OPT_SRC_BIT]; // [R5]
    wire logic psaWdt = option_r[OPT_PSA_BIT]; // [R6]
    wire logic [2:0] psSel = option_r[OPT_PS_LSB +: 3];
    wire logic edgeFall = option_r[OPT_EDGE_BIT];

    logic pinEdge;
    logic preTick;
    pin_edge_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn(externalCountInput),
        .fallingSel(edgeFall),
        .edgePulse(pinEdge)
    );

    // source pick, frozen in sleep [R2] [R4] [R15]
    wire logic rawTick = !sleep_r && (pinMode ? pinEdge : 1'b1);
    // a count write clears the prescaler while the timer owns it [R10]
    wire logic preClear = wrCount && !psaWdt;

    prescale_div u_pre (
        .clk(clk),
        .rst(rst),
        .clear(preClear),
        .tickIn(rawTick),
        .bypass(psaWdt),
        .ratioSel(psSel),
        .tickOut(preTick)
    );

    wire logic doInc = preTick && (hold_r == 2'h0) && !wrCount; // [R3]
    wire logic wrap = doInc && (timerCount_r == COUNT_MAX);

    always_comb begin
        timerCount_nxt = timerCount_r;
        hold_nxt = hold_r;
        if (wrCount) begin
            timerCount_nxt = hwdata[7:0];
            hold_nxt = WRITE_HOLD_CYCLES; // [R3]
        end else begin
            if (hold_r != 2'h0) begin
                hold_nxt = hold_r - 2'h1;
            end
            if (doInc) begin
                timerCount_nxt = timerCount_r + 8'h01; // [R1] [R17]
            end
        end
    end

    always_comb begin
        overflowFlag_nxt = overflowFlag_r;
        if (wrIntctl) begin
            overflowFlag_nxt = hwdata[ICTL_FLAG_BIT];
        end
        if (wrap) begin
            overflowFlag_nxt = 1'b1; // [R12] [R13]
        end
    end

    wire logic [31:0] readWord =
        rdCount ? {24'h000000, timerCount_r} :
        rdOption ? {24'h000000, option_r} :
        rdIntctl ? {26'h0000000, overflowEnable_r, 2'h0,
                    overflowFlag_r, 2'h0} :
        rdSleep ? {31'h00000000, sleep_r} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            timerCount_r <= COUNT_RESET; // [R18]
            hold_r <= 2'h0;
            overflowFlag_r <= 1'b0;
        end else begin
            timerCount_r <= timerCount_nxt;
            hold_r <= hold_nxt;
            overflowFlag_r <= overflowFlag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            option_r <= OPTION_RESET;
            overflowEnable_r <= 1'b0; // [R18]
            sleep_r <= 1'b0;
        end else begin
            if (wrOption) begin
                option_r <= hwdata[7:0];
            end
            if (wrIntctl) begin
                overflowEnable_r <= hwdata[ICTL_EN_BIT];
            end
            if (wrSleep) begin
                sleep_r <= hwdata[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            wrAddr_r <= aLow;
            if (addrPhase && !hwrite) begin
                hrdata_r <= readWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            overflowIrq_r <= 1'b0;
            prescaleToWatchdog_r <= 1'b0;
            watchdogPrescale_r <= 3'h0;
        end else begin
            overflowIrq_r <= overflowFlag_nxt && overflowEnable_r; // [R14]
            prescaleToWatchdog_r <= psaWdt; // [R6] [R11]
            watchdogPrescale_r <= psSel;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign overflowIrq = overflowIrq_r;
    assign prescaleToWatchdog = prescaleToWatchdog_r;
    assign watchdogPrescaleSelect = watchdogPrescale_r;

    wrap_sets_flag_a: assert property (@(posedge clk) disable iff (rst)
        wrap |=> overflowFlag_r) // [R12]
        else $error("overflow wrap did not set flag");

    flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
        overflowFlag_r && !wrIntctl |=> overflowFlag_r) // [R13]
        else $error("flag cleared without software");

    write_hold_a: assert property (@(posedge clk) disable iff (rst)
        wrCount |=> !doInc [*2]) // [R3]
        else $error("count advanced inside write hold");

    timer_step_a: assert property (@(posedge clk) disable iff (rst)
        !pinMode && psaWdt && !sleep_r && hold_r == 2'h0 && !wrCount
        |=> timerCount_r == $past(timerCount_r) + 8'h01) // [R2] [R9]
        else $error("undivided timer failed to step");

    sleep_hold_a: assert property (@(posedge clk) disable iff (rst)
        sleep_r && !wrCount |=> $stable(timerCount_r)) // [R15] [R17]
        else $error("count moved during sleep");

    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        overflowIrq_r |-> $past(overflowEnable_r)) // [R14]
        else $error("irq without enable");

    pin_only_a: assert property (@(posedge clk) disable iff (rst)
        pinMode && !pinEdge |-> !doInc) // [R4] [R5]
        else $error("counter mode stepped without edge");

    div_two_a: assert property (@(posedge clk) disable iff (rst)
        preTick && !psaWdt && psSel == 3'h0 && !preClear && !wrOption
        |=> !preTick) // [R7] [R8]
        else $error("divide by two ticked twice in a row");

    // reset leaves count, flag and enable cleared
    reset_clear_a: assert property (@(posedge clk)
        rst
        |=> timerCount_r == COUNT_RESET && !overflowFlag_r
            && !overflowEnable_r) // [R18]
        else $error("reset left state behind");

    option_load_a: assert property (@(posedge clk) disable iff (rst)
        wrOption
        |=> option_r == $past(hwdata[7:0])) // [R5] [R6]
        else $error("option write not taken");

    enable_load_a: assert property (@(posedge clk) disable iff (rst)
        wrIntctl
        |=> overflowEnable_r == $past(hwdata[ICTL_EN_BIT])) // [R14]
        else $error("enable write not taken");

    soft_clear_a: assert property (@(posedge clk) disable iff (rst)
        wrIntctl && !hwdata[ICTL_FLAG_BIT] && !wrap
        |=> !overflowFlag_r) // [R13]
        else $error("software clear of flag lost");

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        wrIntctl && wrap
        |=> overflowFlag_r) // [R12]
        else $error("clear beat a wrap in the same cycle");

    flag_source_a: assert property (@(posedge clk) disable iff (rst)
        !overflowFlag_r && !wrap && !wrIntctl
        |=> !overflowFlag_r) // [R12] [R13]
        else $error("flag set with no wrap");

    count_load_a: assert property (@(posedge clk) disable iff (rst)
        wrCount
        |=> timerCount_r == $past(hwdata[7:0])) // [R3]
        else $error("count write not taken");

    hold_load_a: assert property (@(posedge clk) disable iff (rst)
        wrCount
        |=> hold_r == WRITE_HOLD_CYCLES) // [R3]
        else $error("write hold not armed");

    pre_clear_a: assert property (@(posedge clk) disable iff (rst)
        preClear
        |=> u_pre.count_r == PRESCALE_RESET) // [R10]
        else $error("count write left prescaler running");

    bypass_idle_a: assert property (@(posedge clk) disable iff (rst)
        psaWdt
        |=> u_pre.count_r == PRESCALE_RESET) // [R9]
        else $error("prescaler moved while given away");

    owner_copy_a: assert property (@(posedge clk) disable iff (rst)
        1'b1
        |=> prescaleToWatchdog_r == $past(psaWdt)
            && watchdogPrescale_r == $past(psSel)) // [R6]
        else $error("prescaler owner outputs stale");

    irq_follow_a: assert property (@(posedge clk) disable iff (rst)
        overflowFlag_r && overflowEnable_r && !wrIntctl
        |=> overflowIrq_r) // [R14]
        else $error("irq missing with flag and enable");

    step_size_a: assert property (@(posedge clk) disable iff (rst)
        !wrCount
        |=> timerCount_r == $past(timerCount_r)
            || timerCount_r == $past(timerCount_r) + 8'h01) // [R1]
        else $error("count jumped by more than one");

    sleep_flag_a: assert property (@(posedge clk) disable iff (rst)
        sleep_r && !wrIntctl && !overflowFlag_r
        |=> !overflowFlag_r) // [R15]
        else $error("overflow raised during sleep");

    edge_phase_a: assert property (@(posedge clk) disable iff (rst)
        pinEdge
        |-> u_sync.phase_r == PH_FOUR) // [R16]
        else $error("pin edge off phase four");

    edge_space_a: assert property (@(posedge clk) disable iff (rst)
        pinEdge
        |=> !pinEdge [*3]) // [R16]
        else $error("pin edges closer than four cycles");

    read_capture_a: assert property (@(posedge clk) disable iff (rst)
        addrPhase && !hwrite
        |=> hrdata_r == $past(readWord)) // [R1]
        else $error("read data not captured");
endmodule : timer_zero
`default_nettype wire

// *** pulse_source.sv ***
`default_nettype none
module pulse_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [3:0] nEdges,
    input wire logic [7:0] halfWidth,
    output logic pinOut,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left_r;
    logic [7:0] wait_r;
    assign busy = left_r != 4'h0;
    // pin keeps its last level between bursts
    always @(posedge clk) begin
        if (rst) begin
            pinOut <= 1'b0;
            left_r <= 4'h0;
            wait_r <= 8'h00;
        end else if (left_r == 4'h0) begin
            left_r <= go ? nEdges : 4'h0;
            wait_r <= halfWidth;
        end else if (wait_r == 8'h00) begin
            // each level stands halfWidth+1 cycles
            pinOut <= ~pinOut;
            left_r <= left_r - 4'h1;
            wait_r <= halfWidth;
        end else begin
            wait_r <= wait_r - 8'h01;
        end
    end
endmodule : pulse_source
`default_nettype wire

// *** tb_timer_zero.sv ***
`default_nettype none
module tb_timer_zero import timer_zero_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, pin, go, busy;
    logic overflowIrq, prescaleToWatchdog;
    logic [2:0] hsize, watchdogPrescaleSelect;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r1, r2;
    logic [3:0] nEdges;
    wire hready = hreadyout;
    int badCount, checks, cyc;
    timer_zero timer_zero_inst (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .externalCountInput(pin),
        .overflowIrq(overflowIrq), .prescaleToWatchdog(prescaleToWatchdog),
        .watchdogPrescaleSelect(watchdogPrescaleSelect));
    pulse_source pulse_source_inst (.clk(clk), .rst(rst), .go(go),
        .nEdges(nEdges), .halfWidth(8'h06), .pinOut(pin), .busy(busy));
    task automatic tally_and_finish();
        if (badCount == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] o,
                       input logic [31:0] d, output logic [31:0] v);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, o};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        v = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, o, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] o, output logic [31:0] v);
        bus(1'b0, o, 32'h00000000, v);
    endtask : rd
    task automatic rdchk(input logic [7:0] o, input logic [31:0] e);
        logic [31:0] v;
        rd(o, v);
        chk(v, e);
    endtask : rdchk
    task automatic pulses(input logic [3:0] n);
        nEdges <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 300 && busy === 1'b1; i++) @(posedge clk);
        repeat (16) @(posedge clk);
    endtask : pulses
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            badCount++;
            tally_and_finish();
        end
    end
    initial begin
        {rst, hsel, hwrite, go, htrans, haddr, hwdata} = '0;
        rst = 1'b1;
        hsize = 3'h2;
        nEdges = 4'h0;
        badCount = 0;
        checks = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_COUNT, r1);
        chk({25'h0, r1[7:1]}, 32'h0);
        for (int i = 1; i < 5; i++) rdchk(8'(i * 4), 32'h0);
        chk({31'h0, overflowIrq}, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        wr(8'h10, 32'h000000ff);
        rdchk(8'h10, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_OPTION, 32'(k));
            repeat (2) @(negedge clk);
            chk({31'h0, prescaleToWatchdog}, 32'h0);
            chk({29'h0, watchdogPrescaleSelect}, 32'(k));
            rd(OFS_COUNT, r1);
            repeat ((8 << k) - 3) @(posedge clk);
            rd(OFS_COUNT, r2);
            chk({24'h0, r2[7:0] - r1[7:0]}, 32'h4);
        end
        wr(OFS_COUNT, 32'h0);
        repeat (100) @(posedge clk);
        wr(OFS_COUNT, 32'h0);
        repeat (200) @(posedge clk);
        rdchk(OFS_COUNT, 32'h0);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_OPTION, 32'h08);
        repeat (2) @(negedge clk);
        chk({31'h0, prescaleToWatchdog}, 32'h1);
        rd(OFS_COUNT, r1);
        repeat (17) @(posedge clk);
        rd(OFS_COUNT, r2);
        chk({24'h0, r2[7:0] - r1[7:0]}, 32'h14);
        wr(OFS_INTCTL, 32'h0);
        wr(OFS_COUNT, 32'hf0);
        repeat (30) @(posedge clk);
        rdchk(OFS_INTCTL, 32'h04);
        chk({31'h0, overflowIrq}, 32'h0);
        wr(OFS_INTCTL, 32'h24);
        repeat (2) @(posedge clk);
        chk({31'h0, overflowIrq}, 32'h1);
        repeat (50) @(posedge clk);
        rdchk(OFS_INTCTL, 32'h24);
        wr(OFS_INTCTL, 32'h20);
        repeat (2) @(posedge clk);
        chk({31'h0, overflowIrq}, 32'h0);
        wr(OFS_SLEEP, 32'h1);
        wr(OFS_COUNT, 32'hfe);
        wr(OFS_INTCTL, 32'h20);
        repeat (40) @(posedge clk);
        rdchk(OFS_INTCTL, 32'h20);
        rdchk(OFS_COUNT, 32'hfe);
        // same bus timing, but a count write loses two increments
        wr(OFS_COUNT, 32'h10);
        wr(OFS_SLEEP, 32'h0);
        repeat (20) @(posedge clk);
        rd(OFS_COUNT, r1);
        wr(OFS_COUNT, 32'h10);
        repeat (20) @(posedge clk);
        rd(OFS_COUNT, r2);
        chk(r2, r1 - 32'h2);
        wr(OFS_OPTION, 32'h28);
        wr(OFS_COUNT, 32'h0);
        pulses(4'h3);
        rdchk(OFS_COUNT, 32'h2);
        wr(OFS_OPTION, 32'h38);
        wr(OFS_COUNT, 32'h0);
        pulses(4'h3);
        rdchk(OFS_COUNT, 32'h2);
        tally_and_finish();
    end
endmodule : tb_timer_zero
`default_nettype wire
